// file: design/lock_wait_timer.v
// Purpose: counts the clock locking time after the bus clock returns
// Assumes: run is a level, held while waiting
// Notes:   done is a one-cycle pulse when the count runs out
`timescale 1ns/1ps
`default_nettype none

module lock_wait_timer #(
    parameter CYCLES = 250000,
    parameter CNT_W  = 18
) (
    input  wire mclk,
    input  wire rst_n,
    input  wire run,
    output reg  done
);

    localparam [CNT_W-1:0] LAST = CYCLES - 1;

    reg [CNT_W-1:0] count;

    // ************************************************************
    // counter
    // ************************************************************
    // restarts from zero whenever run drops
    always @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            count <= {CNT_W{1'b0}};
            done  <= 1'b0;
        end
        else
        begin
            done <= 1'b0;
            if (!run)
                count <= {CNT_W{1'b0}};
            else if (count == LAST)
            begin
                count <= {CNT_W{1'b0}};
                done  <= 1'b1;
            end
            else
                count <= count + {{(CNT_W-1){1'b0}}, 1'b1};
        end
    end

endmodule // lock_wait_timer

`default_nettype wire

// file: design/low_power_state_control.v
// Purpose: stop-clock power state machine of the processor
// Assumes: all pins synchronous to mclk; bus clock presence is a level
// Notes:   power_state is one-hot, see state localparams
// Operation
// - idle instruction moves Normal to idle powerdown
// - management, bus init, soft init or local irq wakes idle to Normal
// - hard reset in idle powerdown starts initialisation at once
// - management handler return picks Normal or idle powerdown
// - flush in idle powerdown is serviced, then back to idle
// - stop request from idle returns to idle when released
// - asserted stop request enters stop-grant from Normal or idle
// - bus init and flush ignored in stop-grant
// - hard reset in stop-grant initialises but stays in stop-grant
// - stop request released in stop-grant returns to Normal, or to idle if entered from idle
// - snoop in stop-grant or idle goes to snoop state, then back
// - stop-grant latches one of each event, serviced in Normal
// - sleep request honoured only in stop-grant
// - sleep ignores snoops and interrupts; chipset keeps bus static
// - hard reset held in sleep resets directly, skipping stop-grant
// - stopping bus clock in sleep enters deep sleep
// - clocks stop in low states only while config bit 26 is set
// - sleep request released in sleep returns to stop-grant
// - sleep regarded reached 1 ms after bus clock restarts
`timescale 1ns/1ps
`default_nettype none
`include "low_power_state_defines.vh"

module low_power_state_control #(
    parameter LOCK_CYCLES = `LPS_LOCK_TIME_US * `LPS_CLK_MHZ,
    parameter LOCK_CNT_W  = 18
) (
    input  wire        mclk,
    input  wire        rst_n,
    input  wire        stop_clock_request_n,
    input  wire        sleep_request_n,
    input  wire        hard_reset_n,
    input  wire        sys_mgmt_irq_n,
    input  wire        bus_reinit_n,
    input  wire        soft_init_n,
    input  wire [1:0]  local_irq_lines,
    input  wire        flush_request_n,
    input  wire        idle_instr,
    input  wire        smi_return,
    input  wire        smi_return_to_idle,
    input  wire        flush_done,
    input  wire        snoop_seen,
    input  wire        snoop_serviced,
    input  wire        bus_clock_running,
    input  wire        cfg_write,
    input  wire [9:0]  cfg_address,
    input  wire [31:0] cfg_data,
    output reg  [6:0]  power_state,
    output reg         init_start,
    output wire [3:0]  service_events,
    output reg         bus_reinit_service,
    output wire        flush_service,
    output reg         clocks_stopped
);

    // ************************************************************
    // states
    // ************************************************************
    localparam [6:0] ST_NORMAL = 7'h01;
    localparam [6:0] ST_IDLE   = 7'h02;
    localparam [6:0] ST_GRANT  = 7'h04;
    localparam [6:0] ST_SNOOP  = 7'h08;
    localparam [6:0] ST_SLEEP  = 7'h10;
    localparam [6:0] ST_DEEP   = 7'h20;
    localparam [6:0] ST_FLUSH  = 7'h40;

    localparam [4:0] HOLD_LAST = `LPS_RESET_HOLD_CYC - 1;

    // ************************************************************
    // sampled pins, state and helpers
    // ************************************************************
    reg        stopReq, sleepReq, resetReq, flushReq;
    reg        busInitReq, busInitPrev, clockRun;
    reg  [3:0] evLevel, evPrev;
    reg  [6:0] next_state, snoopReturn;
    reg        grantFromIdle, clkStopEnable, next_init;
    reg  [4:0] holdCount;
    reg  [3:0] directService;
    wire [3:0] evEdge, pendRelease;
    wire       busInitEdge, resetHeld, resetStart, wakeEvent, lockDone;

    // low-state check used by the clock stop decision
    function isLowState;
        input [6:0] st;
        begin
            isLowState = (st == ST_GRANT) | (st == ST_SLEEP) | (st == ST_DEEP);
        end
    endfunction

    always @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            stopReq     <= 1'b0;
            sleepReq    <= 1'b0;
            resetReq    <= 1'b0;
            flushReq    <= 1'b0;
            busInitReq  <= 1'b0;
            busInitPrev <= 1'b0;
            evLevel     <= 4'h0;
            evPrev      <= 4'h0;
            clockRun    <= 1'b1;
        end
        else
        begin
            stopReq     <= ~stop_clock_request_n;
            sleepReq    <= ~sleep_request_n;
            resetReq    <= ~hard_reset_n;
            flushReq    <= ~flush_request_n;
            busInitReq  <= ~bus_reinit_n;
            busInitPrev <= busInitReq;
            evLevel     <= {local_irq_lines, ~soft_init_n, ~sys_mgmt_irq_n};
            evPrev      <= evLevel;
            clockRun    <= bus_clock_running;
        end
    end

    assign evEdge      = evLevel & ~evPrev;
    assign busInitEdge = busInitReq & ~busInitPrev;
    assign wakeEvent   = (|evEdge) | busInitEdge;
    assign resetHeld   = resetReq & (holdCount == HOLD_LAST);
    assign resetStart  = resetReq & (holdCount == 5'h00); // first cycle of an assertion

    // hard reset hold counter for sleep and the first-cycle reset detect
    always @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            holdCount <= 5'h00;
        else if (!resetReq)
            holdCount <= 5'h00;
        else if (holdCount != HOLD_LAST)
            holdCount <= holdCount + 5'h01;
    end

    // ************************************************************
    // configuration bit
    // ************************************************************
    // clock stop enable, set after reset
    always @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            clkStopEnable <= `LPS_CFG_CLKSTOP_RST;
        else if (cfg_write && (cfg_address == `LPS_CFG_ADDR))
            clkStopEnable <= cfg_data[`LPS_CFG_CLKSTOP_BIT];
    end

    // ************************************************************
    // next state
    // ************************************************************
    always @*
    begin
        next_state = power_state;
        next_init  = 1'b0;
        case (power_state)
            ST_NORMAL:
            begin
                next_init = resetStart;
                if (stopReq)
                    next_state = ST_GRANT;
                else if (smi_return && smi_return_to_idle)
                    next_state = ST_IDLE;
                else if (idle_instr && !resetReq)
                    next_state = ST_IDLE;
            end
            ST_IDLE:
            begin
                if (resetReq)
                begin
                    next_init  = 1'b1;
                    next_state = ST_NORMAL;
                end
                else if (stopReq)
                    next_state = ST_GRANT;
                else if (snoop_seen)
                    next_state = ST_SNOOP;
                else if (wakeEvent)
                    next_state = ST_NORMAL;
                else if (flushReq)
                    next_state = ST_FLUSH;
            end
            ST_FLUSH:
            begin
                if (resetReq)
                begin
                    next_init  = 1'b1;
                    next_state = ST_NORMAL;
                end
                else if (flush_done)
                    next_state = ST_IDLE;
            end
            ST_GRANT:
            begin
                next_init = resetStart;
                if (!stopReq)
                    next_state = grantFromIdle ? ST_IDLE : ST_NORMAL;
                else if (snoop_seen)
                    next_state = ST_SNOOP;
                else if (sleepReq)
                    next_state = ST_SLEEP;
            end
            ST_SNOOP:
                if (snoop_serviced)
                    next_state = snoopReturn;
            ST_SLEEP:
            begin
                // held reset resets directly, never via stop-grant
                if (resetReq)
                begin
                    next_init  = resetHeld;
                    next_state = resetHeld ? ST_NORMAL : ST_SLEEP;
                end
                else if (!clockRun)
                    next_state = ST_DEEP;
                else if (!sleepReq)
                    next_state = ST_GRANT;
            end
            ST_DEEP:
                if (lockDone)
                    next_state = ST_SLEEP;
            default:
                next_state = ST_NORMAL;
        endcase
    end

    // ************************************************************
    // state registers
    // ************************************************************
    always @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            power_state   <= ST_NORMAL;
            snoopReturn   <= ST_GRANT;
            grantFromIdle <= 1'b0;
            init_start    <= 1'b0;
        end
        else
        begin
            power_state <= next_state;
            init_start  <= next_init;
            if (next_state == ST_SNOOP && power_state != ST_SNOOP)
                snoopReturn <= power_state;
            if (next_state == ST_GRANT && power_state == ST_IDLE)
                grantFromIdle <= 1'b1;
            else if (next_state == ST_GRANT && power_state == ST_NORMAL)
                grantFromIdle <= 1'b0;
        end
    end

    // ************************************************************
    // event servicing
    // ************************************************************
    // latch in stop-grant, release in Normal
    pending_event_latch #(.N(`LPS_EV_COUNT)) uPending (
        .mclk         (mclk),
        .rst_n        (rst_n),
        .setEvent     (evEdge),
        .capture      (power_state == ST_GRANT),
        .drain        (power_state == ST_NORMAL),
        .pending      (),
        .releasePulse (pendRelease)
    );

    // direct service in Normal and idle only
    always @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            directService      <= 4'h0;
            bus_reinit_service <= 1'b0;
        end
        else
        begin
            directService <= ((power_state == ST_NORMAL) | (power_state == ST_IDLE))
                             ? evEdge : 4'h0;
            // bus init not serviced in stop-grant
            bus_reinit_service <= busInitEdge &
                                  ((power_state == ST_NORMAL) | (power_state == ST_IDLE));
        end
    end

    assign service_events = directService | pendRelease;

    assign flush_service = (power_state == ST_FLUSH);

    // ************************************************************
    // clock lock and clock stop
    // ************************************************************
    // lock wait after restart
    lock_wait_timer #(.CYCLES(LOCK_CYCLES), .CNT_W(LOCK_CNT_W)) uLock (
        .mclk   (mclk),
        .rst_n  (rst_n),
        .run    ((power_state == ST_DEEP) & clockRun),
        .done   (lockDone)
    );

    always @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            clocks_stopped <= 1'b0;
        else
            clocks_stopped <= isLowState(next_state) & clkStopEnable;
    end

endmodule // low_power_state_control
`default_nettype wire

// file: design/low_power_state_defines.vh
// Purpose: shared constants of the low power state controller
// Assumes: one clock of 250 MHz
// Notes:   timing counts are derived from printed times in the top module
`ifndef LOW_POWER_STATE_DEFINES_VH
`define LOW_POWER_STATE_DEFINES_VH

// ************************************************************
// clock and timing
// ************************************************************
`define LPS_CLK_MHZ          250
`define LPS_LOCK_TIME_US     1000
`define LPS_RESET_HOLD_CYC   16

// ************************************************************
// configuration register
// ************************************************************
`define LPS_CFG_ADDR         10'h02A
`define LPS_CFG_CLKSTOP_BIT  26
`define LPS_CFG_CLKSTOP_RST  1'b1

// ************************************************************
// event vector positions
// ************************************************************
`define LPS_EV_MGMT          0
`define LPS_EV_INIT          1
`define LPS_EV_NMI           2
`define LPS_EV_MASKABLE      3
`define LPS_EV_COUNT         4

`endif

// file: design/pending_event_latch.v
// Purpose: one pending flag per event, released as one-cycle pulses
// Assumes: set and release are synchronous to mclk
// Notes:   a set in the release cycle is kept, one occurrence per event
`timescale 1ns/1ps
`default_nettype none

module pending_event_latch #(
    parameter N = 4
) (
    input  wire         mclk,
    input  wire         rst_n,
    input  wire [N-1:0] setEvent,
    input  wire         capture,
    input  wire         drain,
    output wire [N-1:0] pending,
    output reg  [N-1:0] releasePulse
);

    reg [N-1:0] flags;

    assign pending = flags;

    // ************************************************************
    // pending flags
    // ************************************************************
    genvar i;
    generate
        for (i = 0; i < N; i = i + 1)
        begin : gFlag
            // one pending per event, set wins
            always @(posedge mclk or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    flags[i]        <= 1'b0;
                    releasePulse[i] <= 1'b0;
                end
                else
                begin
                    releasePulse[i] <= drain & flags[i];
                    if (capture & setEvent[i])
                        flags[i] <= 1'b1;
                    else if (drain)
                        flags[i] <= 1'b0;
                end
            end
        end
    endgenerate

endmodule // pending_event_latch

`default_nettype wire

// file: dv/chipset_model.sv
// Purpose: chipset driving power state requests and bus clock
// Assumes: commands are levels changed at mclk rising edges
// Notes:   each pin follows its command one clock later
`timescale 1ns/1ps
`default_nettype none

module chipset_model (
    input  wire logic mclk,
    input  wire logic rst_n,
    input  wire logic wantStop,
    input  wire logic wantSleep,
    input  wire logic wantClockOff,
    input  wire logic wantReset,
    output logic      stop_clock_request_n,
    output logic      sleep_request_n,
    output logic      hard_reset_n,
    output logic      bus_clock_running
);
    // bus clock halts and restarts on command
    // every level stands a whole clock
    // no snoops near sleep; one processor only
    always_ff @(posedge mclk or negedge rst_n)
        if (!rst_n)
            {stop_clock_request_n, sleep_request_n, hard_reset_n, bus_clock_running} <= 4'hF;
        else
            {stop_clock_request_n, sleep_request_n, hard_reset_n, bus_clock_running} <=
                ~{wantStop, wantSleep, wantReset, wantClockOff};
endmodule // chipset_model
`default_nettype wire

// file: dv/low_power_state_checker.sv
// Purpose: port checks of the low power state controller
// Assumes: one clock, rst_n asynchronous and active low
// Notes:   shadows track the clock stop enable and the snoop origin
`timescale 1ns/1ps
`default_nettype none
`include "low_power_state_defines.vh"

module low_power_state_checker (
    input wire logic        mclk,
    input wire logic        rst_n,
    input wire logic        stop_clock_request_n,
    input wire logic        hard_reset_n,
    input wire logic        idle_instr,
    input wire logic        smi_return,
    input wire logic        snoop_seen,
    input wire logic        bus_clock_running,
    input wire logic        cfg_write,
    input wire logic [9:0]  cfg_address,
    input wire logic [31:0] cfg_data,
    input wire logic [6:0]  power_state,
    input wire logic        init_start,
    input wire logic        bus_reinit_service,
    input wire logic        clocks_stopped
);
    logic       cfgBit;
    logic [6:0] snoopFrom;

    // shadow of enable bit and last state outside snoop
    always_ff @(posedge mclk or negedge rst_n)
        if (!rst_n)
        begin
            cfgBit    <= `LPS_CFG_CLKSTOP_RST;
            snoopFrom <= 7'h01;
        end
        else
        begin
            if (cfg_write && cfg_address == `LPS_CFG_ADDR)
                cfgBit <= cfg_data[`LPS_CFG_CLKSTOP_BIT];
            if (power_state != 7'h08)
                snoopFrom <= power_state;
        end

    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);

    // state moves tied to sampled pins and pulses
    idle_entry_a: assert property (
        idle_instr && !smi_return && power_state == 7'h01 && $past(stop_clock_request_n)
        && $past(hard_reset_n) |=> power_state == 7'h02) else $error("idle entry missed");
    stop_entry_a: assert property (
        power_state == 7'h01 && !$past(stop_clock_request_n) |=> power_state == 7'h04)
        else $error("stop grant entry missed");
    sleep_origin_a: assert property (
        $rose(power_state[4]) |-> $past(power_state) inside {7'h04, 7'h20})
        else $error("sleep entered from wrong state");
    grant_exit_a: assert property (
        power_state == 7'h04 && $past(stop_clock_request_n) && $past(hard_reset_n)
        |=> power_state inside {7'h01, 7'h02}) else $error("stop grant exit missed");
    deep_entry_a: assert property (
        power_state == 7'h10 && !$past(bus_clock_running) && $past(hard_reset_n)
        |=> power_state == 7'h20) else $error("deep sleep entry missed");
    sleep_reset_a: assert property (
        $past(power_state) == 7'h10 && power_state == 7'h01 |-> init_start)
        else $error("sleep left to normal without init");
    grant_reset_a: assert property (
        init_start && $past(power_state) == 7'h04 && !$past(stop_clock_request_n, 2)
        && !$past(snoop_seen) |-> power_state == 7'h04) else $error("reset left stop grant");
    grant_ignore_a: assert property (
        power_state == 7'h04 && $past(power_state) == 7'h04 && $past(power_state, 2) == 7'h04
        |-> !bus_reinit_service) else $error("bus init serviced in stop grant");
    clock_gate_a: assert property (
        !$past(cfg_write) && !$past(cfg_write, 2) |-> clocks_stopped ==
        (cfgBit && power_state inside {7'h04, 7'h10, 7'h20})) else $error("clock gate wrong");
    snoop_entry_a: assert property (
        snoop_seen && $past(hard_reset_n) && (power_state == 7'h04 && !$past(stop_clock_request_n)
        || power_state == 7'h02 && $past(stop_clock_request_n)) |=> power_state == 7'h08)
        else $error("snoop entry missed");
    snoop_return_a: assert property (
        $fell(power_state[3]) |-> power_state == snoopFrom) else $error("snoop return wrong");
endmodule // low_power_state_checker

bind low_power_state_control low_power_state_checker low_power_state_checker_i (.*);
`default_nettype wire

// file: dv/low_power_state_control_tb.sv
// Purpose: self-checking bench of the low power state controller
// Assumes: 250 MHz mclk, lock count cut to 20 cycles
// Notes:   chipset model drives request pins and bus clock presence
`timescale 1ns/1ps
`default_nettype none

module low_power_state_control_tb;
    localparam int LOCK = 20;
    logic        mclk, rst_n, wantStop, wantSleep, wantClockOff, wantReset;
    logic        stop_clock_request_n, sleep_request_n, hard_reset_n, bus_clock_running;
    logic        sys_mgmt_irq_n, bus_reinit_n, soft_init_n, flush_request_n, cfg_write;
    logic [1:0]  local_irq_lines;
    logic        idle_instr, smi_return, smi_return_to_idle, flush_done, snoop_seen;
    logic        snoop_serviced, init_start, bus_reinit_service, flush_service, clocks_stopped;
    logic [9:0]  cfg_address;
    logic [31:0] cfg_data;
    logic [6:0]  power_state;
    logic [3:0]  service_events;
    int          fail_count, samples_checked, cycles, reinitSeen, svcSeen, initSeen;
    int          grantSeen, flushSeen;

    low_power_state_control #(.LOCK_CYCLES(LOCK)) low_power_state_control_i (.*);

    chipset_model chipset_model_i (.*);

    // free running clock
    initial
    begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    // cycle ceiling and output tallies
    always @(posedge mclk)
    begin
        cycles++;
        reinitSeen += bus_reinit_service;
        svcSeen    += $countones(service_events);
        initSeen   += init_start;
        grantSeen  += (power_state == 7'h04);
        flushSeen  += flush_service;
        if (cycles == 2000)
        begin
            fail_count++;
            close_out();
        end
    end

    task automatic cmp(input string what, input logic [6:0] exp, input logic [6:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    // one-cycle pulse: 4 idle, 3 handler return, 2 flush done, 1 snoop, 0 serviced
    task automatic pulse(input int w);
        @(posedge mclk);
        {idle_instr, smi_return, flush_done, snoop_seen, snoop_serviced} <= 5'h01 << w;
        @(posedge mclk);
        {idle_instr, smi_return, flush_done, snoop_seen, snoop_serviced} <= 5'h00;
        #1;
    endtask

    task automatic waitState(input logic [6:0] s);
        for (int k = 0; k < 40 && power_state !== s; k++)
            tick(1);
        cmp("power_state", s, power_state);
    endtask

    // drive one wake source at the current edge
    task automatic wake(input int i, input logic on);
        case (i)
            0: sys_mgmt_irq_n <= !on;
            1: bus_reinit_n <= !on;
            2: soft_init_n <= !on;
            3: local_irq_lines[0] <= on;
            default: local_irq_lines[1] <= on;
        endcase
    endtask

    task automatic cfgWrite(input logic [31:0] d);
        @(posedge mclk);
        {cfg_write, cfg_address, cfg_data} <= {1'b1, 10'h02A, d};
        @(posedge mclk);
        cfg_write <= 1'b0;
    endtask

    task automatic t_idle();
        pulse(4);
        cmp("idle entry", 7'h02, power_state);
        pulse(1);
        cmp("snoop entry", 7'h08, power_state);
        pulse(0);
        cmp("snoop return", 7'h02, power_state);
        @(posedge mclk);
        flush_request_n <= 1'b0;
        waitState(7'h40);
        cmp("flush service", 7'h01, flush_service);
        @(posedge mclk);
        flush_request_n <= 1'b1;
        tick(3);
        pulse(2);
        cmp("flush return", 7'h02, power_state);
        @(posedge mclk);
        wantStop <= 1'b1;
        waitState(7'h04);
        @(posedge mclk);
        wantStop <= 1'b0;
        waitState(7'h02);
        {reinitSeen, svcSeen} = '0;
        for (int i = 0; i < 5; i++)
        begin
            @(posedge mclk);
            wake(i, 1'b1);
            waitState(7'h01);
            @(posedge mclk);
            wake(i, 1'b0);
            if (i < 4)
                pulse(4);
        end
        tick(2);
        cmp("reinit service", 7'h01, reinitSeen[6:0]);
        cmp("wake services", 7'h04, svcSeen[6:0]);
        $display("test idle done");
    endtask

    task automatic t_grant();
        waitState(7'h01);
        @(posedge mclk);
        wantStop <= 1'b1;
        waitState(7'h04);
        cmp("clocks stopped", 7'h01, clocks_stopped);
        {reinitSeen, svcSeen, initSeen, flushSeen} = '0;
        @(posedge mclk);
        {bus_reinit_n, flush_request_n, sys_mgmt_irq_n, wantReset} <= 4'b0001;
        @(posedge mclk);
        {bus_reinit_n, sys_mgmt_irq_n, wantReset} <= 3'b110;
        @(posedge mclk);
        sys_mgmt_irq_n <= 1'b0;
        tick(8);
        cmp("grant held", 7'h04, power_state);
        cmp("init starts", 7'h01, initSeen[6:0]);
        cmp("reinit service", 7'h00, reinitSeen[6:0]);
        cmp("flush service", 7'h00, flushSeen[6:0]);
        cmp("early mgmt", 7'h00, svcSeen[6:0]);
        @(posedge mclk);
        {flush_request_n, sys_mgmt_irq_n, wantStop} <= 3'b110;
        waitState(7'h01);
        tick(6);
        cmp("mgmt services", 7'h01, svcSeen[6:0]);
        $display("test grant done");
    endtask

    task automatic t_sleep();
        @(posedge mclk);
        wantSleep <= 1'b1;
        tick(6);
        cmp("sleep ignored", 7'h01, power_state);
        @(posedge mclk);
        wantStop <= 1'b1;
        waitState(7'h10);
        @(posedge mclk);
        wantClockOff <= 1'b1;
        waitState(7'h20);
        cmp("deep gated", 7'h01, clocks_stopped);
        @(posedge mclk);
        wantClockOff <= 1'b0;
        tick(LOCK + 2);
        cmp("lock wait", 7'h20, power_state);
        tick(1);
        cmp("lock done", 7'h10, power_state);
        @(posedge mclk);
        wantSleep <= 1'b0;
        waitState(7'h04);
        @(posedge mclk);
        wantStop <= 1'b0;
        waitState(7'h01);
        $display("test sleep done");
    endtask

    task automatic t_sleep_reset();
        @(posedge mclk);
        {wantStop, wantSleep} <= 2'b11;
        waitState(7'h10);
        {grantSeen, initSeen} = '0;
        @(posedge mclk);
        wantReset <= 1'b1;
        @(posedge mclk);
        {wantStop, wantSleep} <= 2'b00;
        tick(20);
        @(posedge mclk);
        wantReset <= 1'b0;
        waitState(7'h01);
        cmp("init once", 7'h01, initSeen[6:0]);
        cmp("grant skipped", 7'h00, grantSeen[6:0]);
        $display("test sleep reset done");
    endtask

    task automatic t_cfg_smi();
        cfgWrite(32'h00000000);
        @(posedge mclk);
        wantStop <= 1'b1;
        waitState(7'h04);
        cmp("clocks run", 7'h00, clocks_stopped);
        @(posedge mclk);
        wantStop <= 1'b0;
        waitState(7'h01);
        cfgWrite(32'h04000000);
        @(posedge mclk);
        smi_return_to_idle <= 1'b1;
        pulse(3);
        cmp("return idle", 7'h02, power_state);
        @(posedge mclk);
        wake(3, 1'b1);
        waitState(7'h01);
        @(posedge mclk);
        {local_irq_lines, smi_return_to_idle} <= 3'b000;
        pulse(3);
        cmp("return normal", 7'h01, power_state);
        $display("test config and handler done");
    endtask

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // main sequence
    initial
    begin
        {rst_n, wantStop, wantSleep, wantClockOff, wantReset, cfg_write} = '0;
        {sys_mgmt_irq_n, bus_reinit_n, soft_init_n, flush_request_n} = '1;
        {local_irq_lines, idle_instr, smi_return, smi_return_to_idle} = '0;
        {flush_done, snoop_seen, snoop_serviced, cfg_address, cfg_data} = '0;
        {fail_count, samples_checked, cycles} = '0;
        repeat (10) @(posedge mclk);
        rst_n <= 1'b1;
        tick(2);
        cmp("reset state", 7'h01, power_state);
        cmp("reset gate", 7'h00, clocks_stopped);
        t_idle();
        t_grant();
        t_sleep();
        t_sleep_reset();
        t_cfg_smi();
        close_out();
    end
endmodule // low_power_state_control_tb
`default_nettype wire
